/* rtl/supervisor_pkg.sv */
package supervisor_pkg;

    // Register port geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [3:0] OFS_PWR = 4'h0;
    localparam logic [3:0] OFS_WDCTL = 4'h1;
    localparam logic [3:0] OFS_WDREL = 4'h2;
    localparam logic [3:0] OFS_WDCNT = 4'h3;
    localparam logic [3:0] OFS_STAT = 4'h4;

    // Field positions of power_control_reg.
    localparam int PWR_IDLE_ARM = 0;
    localparam int PWR_PD_ARM = 1;
    localparam int PWR_SLOW = 4;
    localparam int PWR_IDLE_GO = 5;
    localparam int PWR_PD_GO = 6;

    // Field positions of the watchdog control register.
    localparam int WD_START = 0;
    localparam int WD_REFRESH = 1;
    localparam int WD_CAUSE = 2;

    // Field positions of the reload register.
    localparam int REL_HI = 6;
    localparam int REL_PRE16 = 7;

    // Reset values.
    localparam logic [7:0] WDREL_RESET = 8'h00;
    localparam logic [14:0] WDCNT_RESET = 15'h0000;

    // Watchdog geometry and prescalers.
    localparam int WD_W = 15;
    localparam logic [14:0] WD_MAX = 15'h7fff;
    localparam logic [3:0] WD_BASE_LAST = 4'h5;
    localparam logic [3:0] WD_PRE16_LAST = 4'hf;

    // Slow-down divider: one enable pulse every 32 clocks.
    localparam logic [4:0] SLOW_LAST = 5'h1f;

    // Internal reset pulse length after a watchdog overflow.
    localparam logic [2:0] WD_RST_CYCLES = 3'h4;

    // Vectors.
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] WAKE_VECTOR = 16'h007b;

    // Oscillator stabilisation delay.
    localparam int CLK_MHZ = 250;
    localparam int STAB_TIME_US = 1000;
    localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
    localparam int STAB_W = 18;

    typedef enum logic [2:0] {
        SUP_POR,
        SUP_STAB,
        SUP_RUN,
        SUP_PD,
        SUP_WAKE,
        SUP_WSTAB
    } sup_state_type;

endpackage

/* rtl/supervisor_power_modes.sv */
// Behaviour
// RL1 - Fifteen-bit watchdog counts at oscillator/12 up to oscillator/192.
// RL2 - Count rate comes through a divide-by-two and a divide-by-16 prescaler.
// RL3 - Only the upper seven counter bits can be loaded.
// RL4 - A valid refresh copies the reload value into the upper seven bits.
// RL5 - Start bit begins counting; software cannot stop a running watchdog.
// RL6 - Overflow of the running watchdog without refresh causes internal reset.
// RL7 - Refresh needs refresh bit then start bit in two consecutive accesses.
// RL8 - Readable flag tells external reset from watchdog overflow reset.
// RL9 - Watchdog holds its count in idle and power-down.
// RL10 - Main oscillator slower than RC: switch to RC clock and hold reset.
// RL11 - Main oscillator good again: hold reset about 1 ms, restart at 0000.
// RL12 - After power-on, the reset sequence runs from RC with same monitoring.
// RL13 - Power-down stops both oscillators; state is kept.
// RL14 - Power-down exits on reset or a low pulse on either wake pin.
// RL15 - Pin wake-up waits for a good oscillator, 1 ms, then wake interrupt.
// RL16 - Wake-up interrupt uses its own vector, not external interrupt 0.
// RL17 - Idle keeps oscillator and peripherals clocked, gates only the CPU.
// RL18 - Idle ends on an enabled peripheral interrupt or hardware reset.
// RL19 - Idle entry needs write of 01H then write of 20H.
// RL20 - Power-down entry needs write of 02H then write of 40H.
// RL21 - Slow-down bit 10H divides CPU and peripheral clocks by 32.
// RL22 - Slow-down and idle combine: peripherals keep the reduced rate.
// RL23 - Second entry write must be the very next access, else disarm.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
module supervisor_power_modes #(
    parameter int STAB_CYCLES = supervisor_pkg::STAB_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [supervisor_pkg::ADDR_W-1:0] addr,
    input wire logic [supervisor_pkg::DATA_W-1:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [supervisor_pkg::DATA_W-1:0] rdata,
    // Oscillator and wake-up inputs
    input wire logic osc_slow,
    input wire logic ext_irq0_pin,
    input wire logic can_receive_pin,
    input wire logic periph_irq,
    // Clock and reset controls
    output logic chip_reset,
    output logic clk_sel_rc,
    output logic main_osc_en,
    output logic rc_osc_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    // Execution start
    output logic exec_pulse,
    output logic [15:0] exec_addr,
    // Mode status
    output logic idle_mode,
    output logic pd_mode,
    output logic slow_mode
);
    import supervisor_pkg::*;

    localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_CYCLES - 1);

    sup_state_type state_q;
    logic [STAB_W-1:0] stab_q;
    logic idle_q;
    logic idle_arm_q;
    logic pd_arm_q;
    logic slow_q;
    logic [4:0] slow_cnt_q;
    logic [7:0] reload_q;
    logic [WD_W-1:0] wd_cnt_q;
    logic wd_run_q;
    logic ref_arm_q;
    logic cause_q;
    logic [3:0] pre_q;
    logic div2_q;
    logic [3:0] div16_q;
    logic [2:0] wd_rst_q;
    logic [DATA_W-1:0] rdata_q;
    logic chip_reset_q;
    logic clk_sel_rc_q;
    logic main_osc_en_q;
    logic rc_osc_en_q;
    logic cpu_clk_en_q;
    logic periph_clk_en_q;
    logic exec_pulse_q;
    logic [15:0] exec_addr_q;
    logic pd_q;

    logic any_acc;
    logic wr_pwr;
    logic wr_wdctl;
    logic clk_tick;
    logic base_wrap;
    logic wd_tick;
    logic wd_ovf;
    logic int_rst;
    logic running;
    logic pd_go;
    logic idle_go;
    logic stab_done;

    ////////////////////////////////////////////////////////////////////////
    // Access decode and common enables

    assign any_acc = we | re;
    assign wr_pwr = we && (addr == OFS_PWR);
    assign wr_wdctl = we && (addr == OFS_WDCTL);
    assign int_rst = (wd_rst_q != 3'h0);
    assign running = (state_q == SUP_RUN) && !int_rst;
    // Every clock consumer sees the same slowed enable.
    assign clk_tick = !slow_q || (slow_cnt_q == SLOW_LAST); // RL21 RL22
    assign idle_go = wr_pwr && wdata[PWR_IDLE_GO] && idle_arm_q; // RL19 RL23
    assign pd_go = wr_pwr && wdata[PWR_PD_GO] && pd_arm_q; // RL20 RL23
    assign stab_done = (stab_q == STAB_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Slow-down divider

    always_ff @(posedge clk) begin
        if (rst) begin
            slow_cnt_q <= 5'h00;
        end else begin
            slow_cnt_q <= slow_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power control register and entry sequences

    always_ff @(posedge clk) begin
        if (rst || int_rst) begin
            idle_arm_q <= 1'b0;
            pd_arm_q <= 1'b0;
            slow_q <= 1'b0; // RL21
        end else if (wr_pwr) begin
            // A write that arms must not also fire from its own bit.
            idle_arm_q <= wdata[PWR_IDLE_ARM] && !idle_go;
            pd_arm_q <= wdata[PWR_PD_ARM] && !pd_go;
            slow_q <= wdata[PWR_SLOW]; // RL21
        end else if (any_acc) begin
            idle_arm_q <= 1'b0; // RL23
            pd_arm_q <= 1'b0; // RL23
        end
    end

    always_ff @(posedge clk) begin
        if (rst || int_rst) begin
            idle_q <= 1'b0; // RL18
        end else if (idle_go && !pd_go) begin
            idle_q <= 1'b1; // RL19
        end else if (periph_irq) begin
            idle_q <= 1'b0; // RL18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog prescaler and counter

    // Base /6 then /2 gives /12; the optional /16 stage gives /192.
    assign base_wrap = clk_tick && (pre_q == WD_BASE_LAST);
    assign wd_tick = base_wrap && div2_q &&
        (!reload_q[REL_PRE16] || (div16_q == WD_PRE16_LAST)); // RL1 RL2
    assign wd_ovf = wd_run_q && wd_tick && !idle_q && running &&
        (wd_cnt_q == WD_MAX); // RL6

    always_ff @(posedge clk) begin
        if (rst || !wd_run_q) begin
            pre_q <= 4'h0;
            div2_q <= 1'b0;
            div16_q <= 4'h0;
        end else if (clk_tick && !idle_q && running) begin // RL9
            if (base_wrap) begin
                pre_q <= 4'h0;
                div2_q <= !div2_q; // RL2
                if (div2_q) begin
                    div16_q <= div16_q + 4'h1; // RL2
                end
            end else begin
                pre_q <= pre_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reload_q <= WDREL_RESET;
        end else if (we && (addr == OFS_WDREL)) begin
            reload_q <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst || int_rst) begin
            ref_arm_q <= 1'b0;
        end else if (any_acc) begin
            ref_arm_q <= wr_wdctl && wdata[WD_REFRESH]; // RL7
        end
    end

    always_ff @(posedge clk) begin
        if (rst || int_rst) begin
            wd_run_q <= 1'b0;
            wd_cnt_q <= WDCNT_RESET;
        end else if (wr_wdctl && wdata[WD_START] &&
                     (!wd_run_q || ref_arm_q)) begin
            wd_run_q <= 1'b1; // RL5
            wd_cnt_q <= {reload_q[REL_HI:0], 8'h00}; // RL3 RL4 RL7
        end else if (wd_run_q && wd_tick && !idle_q && running) begin // RL9
            wd_cnt_q <= wd_cnt_q + 15'h0001; // RL1
        end
    end

    // The cause flag survives the internal reset; only the pin clears it.
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_q <= 1'b0; // RL8
        end else if (wd_ovf) begin
            cause_q <= 1'b1; // RL8
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wd_rst_q <= 3'h0;
        end else if (wd_ovf) begin
            wd_rst_q <= WD_RST_CYCLES; // RL6
        end else if (int_rst) begin
            wd_rst_q <= wd_rst_q - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator supervisor

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SUP_POR; // RL12
            stab_q <= '0;
            pd_q <= 1'b0;
        end else begin
            case (state_q)
                SUP_POR: begin
                    stab_q <= '0;
                    if (!osc_slow) begin
                        state_q <= SUP_STAB; // RL11
                    end
                end
                SUP_STAB: begin
                    stab_q <= stab_q + STAB_W'(1);
                    if (osc_slow) begin
                        state_q <= SUP_POR; // RL10
                    end else if (stab_done) begin
                        state_q <= SUP_RUN; // RL11
                    end
                end
                SUP_RUN: begin
                    stab_q <= '0;
                    if (osc_slow) begin
                        state_q <= SUP_POR; // RL10
                    end else if (pd_go && !int_rst) begin
                        state_q <= SUP_PD; // RL20
                        pd_q <= 1'b1; // RL20
                    end
                end
                SUP_PD: begin
                    if (!ext_irq0_pin || !can_receive_pin) begin
                        state_q <= SUP_WAKE; // RL14
                        pd_q <= 1'b0; // RL14
                    end
                end
                SUP_WAKE: begin
                    stab_q <= '0;
                    if (!osc_slow) begin
                        state_q <= SUP_WSTAB; // RL15
                    end
                end
                SUP_WSTAB: begin
                    stab_q <= stab_q + STAB_W'(1);
                    if (osc_slow) begin
                        state_q <= SUP_WAKE; // RL15
                    end else if (stab_done) begin
                        state_q <= SUP_RUN; // RL15
                    end
                end
                default: begin
                    state_q <= SUP_POR;
                    pd_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge clk) begin
        if (rst) begin
            chip_reset_q <= 1'b1;
            clk_sel_rc_q <= 1'b1;
            main_osc_en_q <= 1'b1;
            rc_osc_en_q <= 1'b1;
        end else begin
            chip_reset_q <= (state_q == SUP_POR) || (state_q == SUP_STAB) ||
                int_rst || wd_ovf; // RL6 RL10 RL11 RL12
            clk_sel_rc_q <= (state_q == SUP_POR) ||
                (state_q == SUP_WAKE); // RL10 RL12
            main_osc_en_q <= (state_q != SUP_PD); // RL13 RL14
            rc_osc_en_q <= (state_q != SUP_PD); // RL13 RL14
        end
    end

    // Gating enables rather than the clock keeps one clean clock tree.
    always_ff @(posedge clk) begin
        if (rst) begin
            cpu_clk_en_q <= 1'b0;
            periph_clk_en_q <= 1'b0;
        end else begin
            cpu_clk_en_q <= clk_tick && running && !idle_q &&
                !wd_ovf; // RL17 RL21
            periph_clk_en_q <= clk_tick && running &&
                !wd_ovf; // RL17 RL22
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            exec_pulse_q <= 1'b0;
            exec_addr_q <= RESET_VECTOR;
        end else if (state_q == SUP_STAB && stab_done && !osc_slow) begin
            exec_pulse_q <= 1'b1;
            exec_addr_q <= RESET_VECTOR; // RL11
        end else if (state_q == SUP_WSTAB && stab_done && !osc_slow) begin
            exec_pulse_q <= 1'b1;
            exec_addr_q <= WAKE_VECTOR; // RL15 RL16
        end else if (wd_rst_q == 3'h1) begin
            exec_pulse_q <= 1'b1;
            exec_addr_q <= RESET_VECTOR;
        end else begin
            exec_pulse_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (re) begin
            case (addr)
                OFS_PWR: begin
                    rdata_q <= {9'h000, (state_q == SUP_PD), idle_q, slow_q,
                        2'b00, pd_arm_q, idle_arm_q};
                end
                OFS_WDCTL: begin
                    rdata_q <= {13'h0000, cause_q, ref_arm_q,
                        wd_run_q}; // RL8
                end
                OFS_WDREL: begin
                    rdata_q <= {8'h00, reload_q};
                end
                OFS_WDCNT: begin
                    rdata_q <= {1'b0, wd_cnt_q};
                end
                OFS_STAT: begin
                    rdata_q <= {13'h0000, state_q};
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata = rdata_q;
    assign chip_reset = chip_reset_q;
    assign clk_sel_rc = clk_sel_rc_q;
    assign main_osc_en = main_osc_en_q;
    assign rc_osc_en = rc_osc_en_q;
    assign cpu_clk_en = cpu_clk_en_q;
    assign periph_clk_en = periph_clk_en_q;
    assign exec_pulse = exec_pulse_q;
    assign exec_addr = exec_addr_q;
    assign idle_mode = idle_q;
    assign pd_mode = pd_q;
    assign slow_mode = slow_q;

endmodule

/* bench/supervisor_power_modes_props.sv */
`timescale 1ns/1ns
module supervisor_power_modes_props #(
    parameter int STAB_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inputs of the block
    input wire logic osc_slow,
    input wire logic ext_irq0_pin,
    input wire logic can_receive_pin,
    input wire logic periph_irq,
    // Outputs of the block
    input wire logic chip_reset,
    input wire logic clk_sel_rc,
    input wire logic main_osc_en,
    input wire logic rc_osc_en,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic exec_pulse,
    input wire logic [15:0] exec_addr,
    input wire logic idle_mode,
    input wire logic pd_mode,
    input wire logic slow_mode
);
    import supervisor_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Counters saturate, so a long quiet stretch can never wrap into a match.
    logic [5:0] gap_q;
    logic [6:0] srun_q;
    logic stab_q;
    int scnt_q;
    always_ff @(posedge clk) begin
        if (rst || periph_clk_en) gap_q <= 6'h00;
        else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
    end
    always_ff @(posedge clk) begin
        if (rst || !slow_mode || pd_mode || chip_reset) srun_q <= 7'h00;
        else if (srun_q != 7'h7f) srun_q <= srun_q + 7'h01;
    end
    always_ff @(posedge clk) begin
        if (rst || !chip_reset) stab_q <= 1'b0;
        else if ($fell(osc_slow)) stab_q <= 1'b1;
    end
    always_ff @(posedge clk) begin
        if (rst || $fell(osc_slow)) scnt_q <= 0;
        else if (scnt_q < 100000) scnt_q <= scnt_q + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_idle_gate;
        idle_mode && $past(idle_mode) |-> !cpu_clk_en;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("cpu clocked");
    property p_idle_exit;
        idle_mode && periph_irq |-> ##[1:3] !idle_mode;
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle kept");
    property p_pd_osc;
        pd_mode && $past(pd_mode) |-> !main_osc_en && !rc_osc_en;
    endproperty
    a_pd_osc: assert property (p_pd_osc) else $error("osc runs in pd");
    property p_pd_wake;
        pd_mode && !(ext_irq0_pin && can_receive_pin)
            |=> !pd_mode ##1 (main_osc_en && rc_osc_en);
    endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no wake");
    property p_vec;
        exec_pulse |-> exec_addr == (chip_reset ? RESET_VECTOR : WAKE_VECTOR);
    endproperty
    a_vec: assert property (p_vec) else $error("bad start address");
    property p_fail;
        $rose(osc_slow) && !chip_reset && !pd_mode
            |-> ##2 chip_reset && clk_sel_rc;
    endproperty
    a_fail: assert property (p_fail) else $error("no fail reset");
    property p_stab_min;
        stab_q && scnt_q < STAB_CYCLES - 2 |-> chip_reset;
    endproperty
    a_stab_min: assert property (p_stab_min) else $error("reset short");
    property p_stab_max;
        stab_q |-> scnt_q <= STAB_CYCLES + 4;
    endproperty
    a_stab_max: assert property (p_stab_max) else $error("reset long");
    property p_slow_gap;
        srun_q > 7'h28 && periph_clk_en |-> gap_q == 6'h1f;
    endproperty
    a_slow_gap: assert property (p_slow_gap) else $error("slow rate");

    c_idle: cover property (idle_mode ##1 !idle_mode);
    c_pd: cover property (pd_mode ##1 !pd_mode);
    c_wake: cover property (exec_pulse && exec_addr == WAKE_VECTOR);
endmodule

bind supervisor_power_modes supervisor_power_modes_props #(
    .STAB_CYCLES(STAB_CYCLES)
) u_props (
    .clk, .rst, .osc_slow, .ext_irq0_pin, .can_receive_pin, .periph_irq,
    .chip_reset, .clk_sel_rc, .main_osc_en, .rc_osc_en, .cpu_clk_en,
    .periph_clk_en, .exec_pulse, .exec_addr, .idle_mode, .pd_mode, .slow_mode
);

/* bench/osc_pin_model.sv */
`timescale 1ns/1ns
module osc_pin_model #(
    parameter int START_CYCLES = 12
) (
    // Clock and oscillator control
    input wire logic clk,
    input wire logic main_osc_en,
    // Scenario requests
    input wire logic fail_req,
    input wire logic [1:0] wake_req,
    // Lines into the block
    output logic osc_slow,
    output logic ext_irq0_pin,
    output logic can_receive_pin
);
    // A crystal needs time to start after power-on and after power-down,
    // so the slow flag stays up until the start-up count has run out.
    int start_q = START_CYCLES;
    always_ff @(posedge clk) begin
        if (main_osc_en == 1'b0) start_q <= START_CYCLES;
        else if (start_q != 0) start_q <= start_q - 1;
    end
    assign osc_slow = fail_req || (start_q != 0);
    // Both wake lines rest high through their pull-ups.
    assign ext_irq0_pin = !wake_req[0];
    assign can_receive_pin = !wake_req[1];
endmodule

/* bench/supervisor_power_modes_tb.sv */
`timescale 1ns/1ns
module supervisor_power_modes_tb;
    import supervisor_pkg::*;
    localparam int STAB = 20;
    localparam int NROW = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic we = 1'b0;
    logic re = 1'b0;
    logic periph_irq = 1'b0;
    logic fail_req = 1'b0;
    logic [1:0] wake_req = 2'b00;
    logic [15:0] rdata, exec_addr, v, w;
    logic osc_slow, ext_irq0_pin, can_receive_pin, chip_reset, clk_sel_rc;
    logic main_osc_en, rc_osc_en, cpu_clk_en, periph_clk_en, exec_pulse;
    logic idle_mode, pd_mode, slow_mode;
    int fail_count = 0;
    int n_tests = 0;
    int nc, np;
    logic [3:0] t_a [NROW] = '{OFS_WDREL, OFS_WDREL, OFS_PWR, OFS_PWR,
        4'hf, OFS_STAT, OFS_WDCNT, OFS_WDCTL};
    logic [15:0] t_d [NROW] = '{16'h00aa, 16'h0055, 16'h0010, 16'h0000,
        16'h1234, 16'hffff, 16'h7fff, 16'h0000};
    logic [15:0] t_e [NROW] = '{16'h00aa, 16'h0055, 16'h0010, 16'h0000,
        16'h0000, 16'h0002, 16'h0000, 16'h0000};

    supervisor_power_modes #(.STAB_CYCLES(STAB)) u_dut (.clk, .rst, .addr,
        .wdata, .we, .re, .rdata, .osc_slow, .ext_irq0_pin, .can_receive_pin,
        .periph_irq, .chip_reset, .clk_sel_rc, .main_osc_en, .rc_osc_en,
        .cpu_clk_en, .periph_clk_en, .exec_pulse, .exec_addr, .idle_mode,
        .pd_mode, .slow_mode);
    osc_pin_model u_osc (.clk, .main_osc_en, .fail_req, .wake_req,
        .osc_slow, .ext_irq0_pin, .can_receive_pin);

    initial begin
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Counts both clock enables, sampled once they have settled.
    task automatic count(input int n);
        nc = 0;
        np = 0;
        repeat (n) begin
            cyc(1);
            if (cpu_clk_en === 1'b1) nc++;
            if (periph_clk_en === 1'b1) np++;
        end
    endtask
    task automatic wait_exec(input int lim);
        for (int i = 0; i < lim && exec_pulse !== 1'b1; i++) cyc(1);
        chk("exec_pulse", 16'h0001, {15'h0, exec_pulse});
    endtask
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #80000;
        fail_count++;
        $display("ERROR run expected finish seen timeout");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(7);
        chk("por_reset", 16'h0001, {15'h0, chip_reset});
        chk("por_rc", 16'h0001, {15'h0, clk_sel_rc});
        @(posedge clk);
        rst <= 1'b0;
        wait_exec(200);
        chk("por_vec", RESET_VECTOR, exec_addr);
        for (int k = 0; k < NROW; k++) begin
            wr(t_a[k], t_d[k]);
            rd(t_a[k], v);
            chk($sformatf("row%0d", k), t_e[k], v);
        end
        wr(OFS_WDREL, 16'h0040);
        wr(OFS_WDCTL, 16'h0001);
        rd(OFS_WDCNT, v);
        chk("wd_load", 16'h0001, {15'h0, (v >= 16'h4000 && v < 16'h4004)});
        cyc(118);
        rd(OFS_WDCNT, w);
        chk("wd_12", 16'h0001, {15'h0, (w - v >= 16'h0009 && w - v <= 16'h000b)});
        wr(OFS_WDREL, 16'h00c0);
        rd(OFS_WDCNT, v);
        cyc(766);
        rd(OFS_WDCNT, w);
        chk("wd_192", 16'h0001, {15'h0, (w - v >= 16'h0003 && w - v <= 16'h0005)});
        wr(OFS_WDREL, 16'h0040);
        wr(OFS_WDCTL, 16'h0000);
        rd(OFS_WDCTL, v);
        chk("wd_run", 16'h0001, {15'h0, v[0]});
        wr(OFS_PWR, 16'h0001);
        wr(OFS_PWR, 16'h0020);
        cyc(3);
        chk("idle", 16'h0001, {15'h0, idle_mode});
        chk("idle_cpu", 16'h0000, {15'h0, cpu_clk_en});
        chk("idle_per", 16'h0001, {15'h0, periph_clk_en});
        rd(OFS_WDCNT, v);
        cyc(60);
        rd(OFS_WDCNT, w);
        chk("wd_hold", v, w);
        @(posedge clk);
        periph_irq <= 1'b1;
        cyc(4);
        chk("idle_exit", 16'h0000, {15'h0, idle_mode});
        @(posedge clk);
        periph_irq <= 1'b0;
        wr(OFS_PWR, 16'h0001);
        rd(OFS_STAT, v);
        wr(OFS_PWR, 16'h0020);
        cyc(3);
        chk("idle_late", 16'h0000, {15'h0, idle_mode});
        wr(OFS_WDREL, 16'h007f);
        wr(OFS_WDCTL, 16'h0002);
        rd(OFS_STAT, v);
        wr(OFS_WDCTL, 16'h0001);
        rd(OFS_WDCNT, v);
        chk("wd_split", 16'h0001, {15'h0, (v < 16'h7f00)});
        wr(OFS_WDCTL, 16'h0002);
        wr(OFS_WDCTL, 16'h0001);
        rd(OFS_WDCNT, v);
        chk("wd_refr", 16'h0001, {15'h0, (v >= 16'h7f00 && v < 16'h7f04)});
        for (int i = 0; i < 3300 && chip_reset !== 1'b1; i++) cyc(1);
        chk("wd_ovf", 16'h0001, {15'h0, chip_reset});
        wait_exec(20);
        rd(OFS_WDCTL, v);
        chk("wd_cause", 16'h0004, v & 16'h0007);
        wr(OFS_PWR, 16'h0010);
        count(64);
        chk("slow_cpu", 16'h0002, 16'(nc));
        chk("slow_per", 16'h0002, 16'(np));
        chk("slow_mode", 16'h0001, {15'h0, slow_mode});
        wr(OFS_PWR, 16'h0011);
        wr(OFS_PWR, 16'h0030);
        cyc(3);
        count(64);
        chk("sidle_cpu", 16'h0000, 16'(nc));
        chk("sidle_per", 16'h0002, 16'(np));
        @(posedge clk);
        periph_irq <= 1'b1;
        cyc(4);
        @(posedge clk);
        periph_irq <= 1'b0;
        wr(OFS_PWR, 16'h0000);
        count(8);
        chk("fast_cpu", 16'h0008, 16'(nc));
        chk("fast_mode", 16'h0000, {15'h0, slow_mode});
        for (int k = 0; k < 2; k++) begin
            wr(OFS_PWR, 16'h0002);
            wr(OFS_PWR, 16'h0040);
            cyc(3);
            chk("pd", 16'h0001, {15'h0, pd_mode});
            chk("pd_osc", 16'h0000, {14'h0, main_osc_en, rc_osc_en});
            cyc(5);
            @(posedge clk);
            wake_req[k] <= 1'b1;
            cyc(2);
            @(posedge clk);
            wake_req <= 2'b00;
            wait_exec(100);
            chk("wake_vec", WAKE_VECTOR, exec_addr);
            chk("wake_rst", 16'h0000, {15'h0, chip_reset});
            rd(OFS_WDREL, v);
            chk("pd_keep", 16'h007f, v);
        end
        @(posedge clk);
        fail_req <= 1'b1;
        cyc(4);
        chk("fail", 16'h0003, {14'h0, chip_reset, clk_sel_rc});
        @(posedge clk);
        fail_req <= 1'b0;
        cyc(STAB / 2);
        chk("fail_stab", 16'h0001, {15'h0, chip_reset});
        wait_exec(100);
        chk("fail_vec", RESET_VECTOR, exec_addr);
        cyc(2);
        chk("fail_end", 16'h0000, {15'h0, chip_reset});
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        @(posedge clk);
        rst <= 1'b0;
        rd(OFS_WDCTL, v);
        chk("hw_cause", 16'h0000, {15'h0, v[2]});
        give_verdict();
    end
endmodule
